/* src/pmcc_pkg.sv */
// Constants and types of the power-mode and clock controller
package pmcc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_PLL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_VREG = 8'h08;
  localparam logic [7:0] ADDR_EBUS = 8'h0c;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_WAKE = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PLL_BYPASS_BIT = 8;
  localparam int PLL_OFF_BIT = 9;
  localparam int PLL_APPLY_BIT = 16;
  localparam int DIV_CORE_LSB = 4;
  localparam int VREG_CORE_OFF_BIT = 4;
  localparam int VREG_DISABLE_BIT = 5;
  localparam int VREG_BYPASS_BIT = 6;
  localparam int MODE_SLEEP_BIT = 0;
  localparam int MODE_DEEP_BIT = 1;
  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] MULT_RESET = 8'h10;
  localparam logic [7:0] MULT_MIN = 8'h01;
  localparam logic [7:0] MULT_MAX = 8'h80;
  localparam logic [3:0] SYS_SEL_RESET = 4'h4;
  localparam logic [1:0] CORE_SEL_RESET = 2'h0;
  localparam logic [3:0] VREG_CODE_RESET = 4'h8;
  localparam logic [11:0] VREG_STEP_MV = 12'h032;
  localparam logic [7:0] RST_SEQ_CYCLES = 8'h10;
  localparam int SYNC_W = 17;
  localparam logic [16:0] SYNC_RESET = 17'h08000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [5:0] {
    M_FULL_ON = 6'b000001,
    M_ACTIVE = 6'b000010,
    M_SLEEP = 6'b000100,
    M_DEEP = 6'b001000,
    M_HIBER = 6'b010000,
    M_RESET = 6'b100000
  } pmcc_mode_type;
  typedef struct packed {
    logic [7:0] mult;
    logic bypass;
    logic pll_off;
    logic [3:0] sys_sel;
    logic [1:0] core_sel;
  } pmcc_clk_cfg_type;
  typedef struct packed {
    logic [3:0] code;
    logic core_off;
    logic reg_disable;
    logic reg_bypass;
  } pmcc_vreg_type;
  localparam pmcc_clk_cfg_type CFG_RESET = '{MULT_RESET, 1'b0, 1'b0, SYS_SEL_RESET, CORE_SEL_RESET};
  localparam pmcc_vreg_type VREG_RESET = '{VREG_CODE_RESET, 1'b0, 1'b0, 1'b0};
endpackage

/* src/pmcc_top.sv */
// Power-mode controller and clock dividers with APB registers
// How it works
// - Deep sleep gates off both core and system clock enables.
// - Deep sleep raises a block on asynchronous peripheral access to resources.
// - Deep sleep exits only on external reset or RTC interrupt.
// - RTC interrupt in deep sleep goes to active mode, PLL bypassed.
// - External reset in deep sleep leads to full-on, PLL not bypassed.
// - Hibernate stops both clocks, switches core supply off, target 0 mV.
// - Hibernate releases all pin drivers except excepted ones.
// - Hibernate wakes on CAN, media, keypad, counter, USB, GPIO, RTC, reset.
// - Any hibernate wake runs the full reset sequence.
// - Regulator code, disable and bypass survive hibernate; core-off and all other registers reset.
// - Regulator target equals base plus code times 50 mV.
// - Software may remove core power, disable or bypass the regulator.
// - Multiplier 0.5 to 64 in half steps, reset 8, applied by sequence.
// - Clock pin driven only when enable bit set; inactive after reset.
// - In full-on and sleep, system clock is VCO divided by select value 1 to 15, reset 4.
// - New system divisor takes effect at once, no relock.
// - In full-on, core clock divides VCO by 1, 2, 4 or 8; reset divide 1.
// - Enabled sleep wake goes to full-on or active by bypass bit.
module pmcc_top import pmcc_pkg::*; #(
  parameter logic [11:0] VREG_BASE_MV = 12'h258
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake pins
  input wire logic ext_reset_n,
  input wire logic rtc_irq,
  input wire logic [6:0] hib_wake,
  input wire logic [7:0] sleep_wake,
  // Clock outputs
  output logic core_clk_en,
  output logic sys_clk_en,
  output logic sys_clk_out_pin,
  output logic sys_clk_out_pin_oe,
  // PLL and regulator
  output logic pll_enable,
  output logic pll_bypass,
  output logic [7:0] pll_mult,
  output logic internal_core_supply_en,
  output logic [11:0] regulator_target_mv,
  output logic regulator_disable,
  output logic regulator_bypass,
  // System control
  output logic periph_access_block,
  output logic pins_hiz,
  output logic sys_reset_out,
  output pmcc_mode_type mode
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
    end else begin
      sync1_r <= {rtc_irq, ext_reset_n, hib_wake, sleep_wake};
      sync2_r <= sync1_r;
    end
  end
  logic rtc_s;
  logic ext_rst_s;
  logic [6:0] hib_s;
  logic [7:0] slp_s;
  assign rtc_s = sync2_r[16];
  assign ext_rst_s = ~sync2_r[15];
  assign hib_s = sync2_r[14:8];
  assign slp_s = sync2_r[7:0];
  // ----------------------------------------
  // State
  // ----------------------------------------
  pmcc_mode_type mode_r, mode_nxt;
  pmcc_clk_cfg_type cfg_r, cfg_nxt;
  pmcc_vreg_type vreg_r, vreg_nxt;
  logic [7:0] mult_pend_r, mult_pend_nxt;
  logic sys_clk_out_pin_en_r, sys_clk_out_pin_en_nxt;
  logic [7:0] wake_en_r, wake_en_nxt;
  logic [7:0] seq_cnt_r, seq_cnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic awake;
  logic wr;
  logic setup;
  logic hit;
  assign awake = (mode_r == M_FULL_ON) || (mode_r == M_ACTIVE);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && awake;
  assign hit = (paddr == ADDR_PLL_CTRL) || (paddr == ADDR_DIV) || (paddr == ADDR_VREG) ||
               (paddr == ADDR_EBUS) || (paddr == ADDR_MODE) || (paddr == ADDR_WAKE);
  // ----------------------------------------
  // Registers, modes and APB
  // ----------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    cfg_nxt = cfg_r;
    vreg_nxt = vreg_r;
    mult_pend_nxt = mult_pend_r;
    sys_clk_out_pin_en_nxt = sys_clk_out_pin_en_r;
    wake_en_nxt = wake_en_r;
    seq_cnt_nxt = seq_cnt_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      pslverr_nxt = !hit;
      case (paddr)
        ADDR_PLL_CTRL: prdata_nxt = {22'h0, cfg_r.pll_off, cfg_r.bypass, cfg_r.mult};
        ADDR_DIV: prdata_nxt = {26'h0, cfg_r.core_sel, cfg_r.sys_sel};
        ADDR_VREG: prdata_nxt = {25'h0, vreg_r.reg_bypass, vreg_r.reg_disable, vreg_r.core_off, vreg_r.code};
        ADDR_EBUS: prdata_nxt = {31'h0, sys_clk_out_pin_en_r};
        ADDR_MODE: prdata_nxt = {26'h0, mode_r};
        ADDR_WAKE: prdata_nxt = {24'h0, wake_en_r};
        default: prdata_nxt = 32'h0;
      endcase
    end
    if (wr) begin
      case (paddr)
        ADDR_PLL_CTRL: begin
          if (pwdata[7:0] >= MULT_MIN && pwdata[7:0] <= MULT_MAX) begin
            mult_pend_nxt = pwdata[7:0];
          end
          if (pwdata[PLL_APPLY_BIT]) begin
            cfg_nxt.mult = mult_pend_r;
          end
          cfg_nxt.bypass = pwdata[PLL_BYPASS_BIT];
          cfg_nxt.pll_off = pwdata[PLL_OFF_BIT] && pwdata[PLL_BYPASS_BIT];
        end
        ADDR_DIV: begin
          if (pwdata[3:0] != 4'h0) begin
            cfg_nxt.sys_sel = pwdata[3:0];
          end
          cfg_nxt.core_sel = pwdata[DIV_CORE_LSB +: 2];
        end
        ADDR_VREG: begin
          vreg_nxt.code = pwdata[3:0];
          vreg_nxt.core_off = pwdata[VREG_CORE_OFF_BIT];
          vreg_nxt.reg_disable = pwdata[VREG_DISABLE_BIT];
          vreg_nxt.reg_bypass = pwdata[VREG_BYPASS_BIT];
        end
        ADDR_EBUS: sys_clk_out_pin_en_nxt = pwdata[0];
        ADDR_WAKE: wake_en_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    case (mode_r)
      M_FULL_ON, M_ACTIVE: begin
        mode_nxt = cfg_nxt.bypass ? M_ACTIVE : M_FULL_ON;
        if (vreg_nxt.core_off) begin
          mode_nxt = M_HIBER;
        end else if (wr && paddr == ADDR_MODE && pwdata[MODE_DEEP_BIT]) begin
          mode_nxt = M_DEEP;
        end else if (wr && paddr == ADDR_MODE && pwdata[MODE_SLEEP_BIT] && !cfg_nxt.pll_off) begin
          mode_nxt = M_SLEEP;
        end
      end
      M_SLEEP: begin
        if ((slp_s & wake_en_r) != 8'h0) begin
          mode_nxt = cfg_r.bypass ? M_ACTIVE : M_FULL_ON;
        end
      end
      M_DEEP: begin
        if (rtc_s) begin
          mode_nxt = M_ACTIVE;
          cfg_nxt.bypass = 1'b1;
          cfg_nxt.pll_off = 1'b0;
        end
      end
      M_HIBER: begin
        if (hib_s != 7'h0) begin
          mode_nxt = M_RESET;
          seq_cnt_nxt = RST_SEQ_CYCLES;
        end
      end
      M_RESET: begin
        cfg_nxt = CFG_RESET;
        mult_pend_nxt = MULT_RESET;
        sys_clk_out_pin_en_nxt = 1'b0;
        wake_en_nxt = 8'h0;
        vreg_nxt.core_off = 1'b0;
        if (seq_cnt_r != 8'h0) begin
          seq_cnt_nxt = seq_cnt_r - 8'h01;
        end else if (!ext_rst_s) begin
          mode_nxt = M_FULL_ON;
        end
      end
      default: mode_nxt = M_RESET;
    endcase
    if (ext_rst_s) begin
      mode_nxt = M_RESET;
      seq_cnt_nxt = RST_SEQ_CYCLES;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_r <= M_RESET;
      cfg_r <= CFG_RESET;
      vreg_r <= VREG_RESET;
      mult_pend_r <= MULT_RESET;
      sys_clk_out_pin_en_r <= 1'b0;
      wake_en_r <= 8'h0;
      seq_cnt_r <= RST_SEQ_CYCLES;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cfg_r <= cfg_nxt;
      vreg_r <= vreg_nxt;
      mult_pend_r <= mult_pend_nxt;
      sys_clk_out_pin_en_r <= sys_clk_out_pin_en_nxt;
      wake_en_r <= wake_en_nxt;
      seq_cnt_r <= seq_cnt_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r && psel && penable;
  // ----------------------------------------
  // Clock dividers
  // ----------------------------------------
  logic [3:0] sys_cnt_r, sys_cnt_nxt;
  logic [2:0] core_cnt_r, core_cnt_nxt;
  logic sys_en_r, sys_en_nxt;
  logic core_en_r, core_en_nxt;
  logic pin_r, pin_nxt;
  logic pin_oe_r, pin_oe_nxt;
  logic sys_run;
  logic core_run;
  logic [2:0] core_lim;
  assign sys_run = awake || (mode_r == M_SLEEP);
  assign core_run = awake;
  assign core_lim = 3'((4'h1 << cfg_r.core_sel) - 4'h1);
  always_comb begin
    sys_cnt_nxt = sys_cnt_r;
    core_cnt_nxt = core_cnt_r;
    sys_en_nxt = 1'b0;
    core_en_nxt = 1'b0;
    if (mode_r == M_ACTIVE) begin
      sys_en_nxt = 1'b1;
      core_en_nxt = 1'b1;
      sys_cnt_nxt = 4'h0;
      core_cnt_nxt = 3'h0;
    end else begin
      if (sys_cnt_r >= cfg_r.sys_sel - 4'h1) begin
        sys_cnt_nxt = 4'h0;
        sys_en_nxt = sys_run;
      end else begin
        sys_cnt_nxt = sys_cnt_r + 4'h1;
      end
      if (core_cnt_r >= core_lim) begin
        core_cnt_nxt = 3'h0;
        core_en_nxt = core_run;
      end else begin
        core_cnt_nxt = core_cnt_r + 3'h1;
      end
    end
    pin_oe_nxt = sys_clk_out_pin_en_r && (mode_r != M_HIBER);
    pin_nxt = pin_oe_nxt && sys_en_nxt;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      sys_cnt_r <= 4'h0;
      core_cnt_r <= 3'h0;
      sys_en_r <= 1'b0;
      core_en_r <= 1'b0;
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      sys_cnt_r <= sys_cnt_nxt;
      core_cnt_r <= core_cnt_nxt;
      sys_en_r <= sys_en_nxt;
      core_en_r <= core_en_nxt;
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end
  assign sys_clk_en = sys_en_r;
  assign core_clk_en = core_en_r;
  assign sys_clk_out_pin = pin_r;
  assign sys_clk_out_pin_oe = pin_oe_r;
  // ----------------------------------------
  // PLL, regulator and system outputs
  // ----------------------------------------
  logic [11:0] target_r, target_nxt;
  always_comb begin
    target_nxt = VREG_BASE_MV + 12'(vreg_r.code * VREG_STEP_MV);
    if (mode_r == M_HIBER) begin
      target_nxt = 12'h000;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      target_r <= 12'h000;
    end else begin
      target_r <= target_nxt;
    end
  end
  assign regulator_target_mv = target_r;
  assign internal_core_supply_en = (mode_r != M_HIBER);
  assign regulator_disable = vreg_r.reg_disable;
  assign regulator_bypass = vreg_r.reg_bypass;
  assign pll_enable = !((mode_r == M_DEEP) || (mode_r == M_HIBER) || ((mode_r == M_ACTIVE) && cfg_r.pll_off));
  assign pll_bypass = (mode_r == M_ACTIVE);
  assign pll_mult = cfg_r.mult;
  assign periph_access_block = (mode_r == M_DEEP) || (mode_r == M_HIBER);
  assign pins_hiz = (mode_r == M_HIBER);
  assign sys_reset_out = (mode_r == M_RESET);
  assign mode = mode_r;
endmodule

/* verif/pmcc_monitor.sv */
// Port checker of the power-mode and clock controller
module pmcc_monitor import pmcc_pkg::*; #(
  parameter logic [11:0] VREG_BASE_MV = 12'h258
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Clocks and pin
  input wire logic core_clk_en,
  input wire logic sys_clk_en,
  input wire logic sys_clk_out_pin,
  input wire logic sys_clk_out_pin_oe,
  // PLL, supply and control
  input wire logic pll_enable,
  input wire logic pll_bypass,
  input wire logic internal_core_supply_en,
  input wire logic [11:0] regulator_target_mv,
  input wire logic periph_access_block,
  input wire logic pins_hiz,
  input wire pmcc_mode_type mode
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_DEEP_CLK: assert property (mode == M_DEEP && $past(mode) == M_DEEP |-> !core_clk_en && !sys_clk_en)
    else $error("clock enable in deep sleep");
  AST_DEEP_BLOCK: assert property (mode == M_DEEP && $past(mode) == M_DEEP |-> periph_access_block)
    else $error("access not blocked in deep sleep");
  AST_DEEP_EXIT: assert property ($past(mode) == M_DEEP |-> mode inside {M_DEEP, M_ACTIVE, M_RESET})
    else $error("bad exit from deep sleep");
  AST_ACTIVE_PLL: assert property (mode == M_ACTIVE |-> pll_bypass && ($past(mode) != M_DEEP || pll_enable))
    else $error("active mode without bypassed pll");
  AST_FULL_PLL: assert property (mode == M_FULL_ON |-> pll_enable && !pll_bypass)
    else $error("full-on mode with bad pll state");
  AST_HIB_OFF: assert property (mode == M_HIBER && $past(mode, 2) == M_HIBER |->
    !internal_core_supply_en && regulator_target_mv == 12'h000 && !core_clk_en && !sys_clk_en)
    else $error("supply or clock alive in hibernate");
  AST_HIB_PINS: assert property (mode == M_HIBER && $past(mode) == M_HIBER |-> pins_hiz && !sys_clk_out_pin_oe)
    else $error("pins driven in hibernate");
  AST_HIB_WAKE: assert property ($fell(mode == M_HIBER) |-> mode == M_RESET)
    else $error("hibernate wake without reset sequence");
  AST_TARGET_STEP: assert property (mode == M_FULL_ON |-> (regulator_target_mv - VREG_BASE_MV) % 12'h032 == 12'h000)
    else $error("regulator target off the step grid");
  AST_SYS_CLK_OUT_PIN_RST: assert property ($past(reset) |-> !sys_clk_out_pin_oe && !sys_clk_out_pin)
    else $error("clock pin active after reset");
  AST_SLEEP_EXIT: assert property ($past(mode) == M_SLEEP |-> mode inside {M_SLEEP, M_FULL_ON, M_ACTIVE, M_RESET})
    else $error("bad exit from sleep");
endmodule

bind pmcc_top pmcc_monitor #(.VREG_BASE_MV(VREG_BASE_MV)) u_mon (.clock(clock), .reset(reset),
  .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en), .sys_clk_out_pin(sys_clk_out_pin),
  .sys_clk_out_pin_oe(sys_clk_out_pin_oe), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
  .internal_core_supply_en(internal_core_supply_en), .regulator_target_mv(regulator_target_mv),
  .periph_access_block(periph_access_block), .pins_hiz(pins_hiz), .mode(mode));

/* verif/power_mode_clock_control_test.sv */
// Scenario bench of the power-mode and clock controller
module power_mode_clock_control_test import pmcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam logic [11:0] BASE = 12'h258;
  logic clock, reset, psel, penable, pwrite, ext_reset_n, rtc_irq;
  logic [7:0] paddr, sleep_wake, pll_mult;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] hib_wake;
  logic pready, pslverr, rerr, core_clk_en, sys_clk_en, sys_clk_out_pin, sys_clk_out_pin_oe, pll_enable, pll_bypass;
  logic internal_core_supply_en, regulator_disable, regulator_bypass, periph_access_block, pins_hiz, sys_reset_out;
  logic [11:0] regulator_target_mv;
  pmcc_mode_type mode;
  int error_cnt = 0;
  int n_checks = 0;
  pmcc_top #(.VREG_BASE_MV(BASE)) uut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_n(ext_reset_n), .rtc_irq(rtc_irq), .hib_wake(hib_wake), .sleep_wake(sleep_wake),
    .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en), .sys_clk_out_pin(sys_clk_out_pin),
    .sys_clk_out_pin_oe(sys_clk_out_pin_oe), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
    .pll_mult(pll_mult), .internal_core_supply_en(internal_core_supply_en),
    .regulator_target_mv(regulator_target_mv), .regulator_disable(regulator_disable),
    .regulator_bypass(regulator_bypass), .periph_access_block(periph_access_block), .pins_hiz(pins_hiz),
    .sys_reset_out(sys_reset_out), .mode(mode));
  always #50 clock = ~clock;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode(input pmcc_mode_type m, input int pre);
    repeat (pre) @(negedge clock);
    for (int i = 0; i < 100 && mode !== m; i++) @(negedge clock);
    chk("mode", m, mode);
    @(posedge clock);
  endtask
  task automatic per_chk(input int sel, input int exp);
    int n = 0;
    int hits = 0;
    logic s;
    for (int i = 0; i < 80 && hits < 2; i++) begin
      @(negedge clock);
      s = sel == 0 ? sys_clk_en : sel == 1 ? core_clk_en : sys_clk_out_pin;
      if (hits == 1) n++;
      if (s === 1'b1) hits++;
    end
    chk("period", exp, n);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    wait_mode(M_FULL_ON, 0);
    apb(0, ADDR_PLL_CTRL, 0);
    chk("mult", MULT_RESET, rd & 32'hff);
    apb(0, ADDR_DIV, 0);
    chk("div", 32'(CORE_SEL_RESET) << DIV_CORE_LSB | 32'(SYS_SEL_RESET), rd & 32'h3f);
    chk("sys_clk_out_pin oe", 0, sys_clk_out_pin_oe);
    chk("target", BASE + 12'(VREG_CODE_RESET) * VREG_STEP_MV, regulator_target_mv);
    apb(0, 8'h18, 0);
    chk("unmapped err", 1, rerr);
  endtask
  task automatic t_div;
    int sv[3] = '{2, 15, 1};
    for (int i = 0; i < 3; i++) begin
      apb(1, ADDR_DIV, sv[i]);
      per_chk(0, sv[i]);
    end
    apb(1, ADDR_DIV, 0);
    apb(0, ADDR_DIV, 0);
    chk("div zero", 1, rd & 32'hf);
    for (int c = 0; c < 4; c++) begin
      apb(1, ADDR_DIV, c << DIV_CORE_LSB | 3);
      per_chk(1, 1 << c);
    end
    apb(1, ADDR_EBUS, 1);
    repeat (3) @(posedge clock);
    chk("sys_clk_out_pin oe", 1, sys_clk_out_pin_oe);
    per_chk(2, 3);
    apb(1, ADDR_EBUS, 0);
  endtask
  task automatic t_mult;
    apb(1, ADDR_PLL_CTRL, 32'h20);
    apb(0, ADDR_PLL_CTRL, 0);
    chk("mult held", MULT_RESET, rd & 32'hff);
    apb(1, ADDR_PLL_CTRL, 32'h81);
    apb(1, ADDR_PLL_CTRL, 32'h1 << PLL_APPLY_BIT);
    apb(0, ADDR_PLL_CTRL, 0);
    chk("mult applied", 32'h20, rd & 32'hff);
    chk("mult port", 8'h20, pll_mult);
    apb(1, ADDR_PLL_CTRL, 32'h1 << PLL_BYPASS_BIT | 32'h1 << PLL_OFF_BIT);
    wait_mode(M_ACTIVE, 0);
    chk("pll off", 0, pll_enable);
    apb(1, ADDR_MODE, 32'h1 << MODE_SLEEP_BIT);
    repeat (4) @(posedge clock);
    chk("sleep refused", M_ACTIVE, mode);
    apb(1, ADDR_PLL_CTRL, 0);
    wait_mode(M_FULL_ON, 0);
  endtask
  task automatic t_sleep;
    apb(1, ADDR_WAKE, 32'h1);
    for (int b = 0; b < 2; b++) begin
      apb(1, ADDR_PLL_CTRL, b << PLL_BYPASS_BIT);
      apb(1, ADDR_MODE, 32'h1 << MODE_SLEEP_BIT);
      wait_mode(M_SLEEP, 0);
      sleep_wake <= 8'h02;
      wait_mode(M_SLEEP, 8);
      sleep_wake <= 8'h01;
      wait_mode(b ? M_ACTIVE : M_FULL_ON, 0);
      sleep_wake <= 8'h00;
    end
  endtask
  task automatic t_deep;
    apb(1, ADDR_DIV, 32'h2);
    apb(1, ADDR_MODE, 32'h3);
    wait_mode(M_DEEP, 0);
    sleep_wake <= 8'h01;
    hib_wake <= 7'h7f;
    wait_mode(M_DEEP, 10);
    chk("block", 1, periph_access_block);
    chk("clk en", 0, {core_clk_en, sys_clk_en});
    sleep_wake <= 8'h00;
    hib_wake <= 7'h00;
    rtc_irq <= 1'b1;
    wait_mode(M_ACTIVE, 0);
    chk("bypass", 1, pll_bypass);
    rtc_irq <= 1'b0;
    apb(1, ADDR_MODE, 32'h1 << MODE_DEEP_BIT);
    wait_mode(M_DEEP, 0);
    ext_reset_n <= 1'b0;
    wait_mode(M_RESET, 0);
    ext_reset_n <= 1'b1;
    wait_mode(M_FULL_ON, 0);
    chk("pll", 2'b10, {pll_enable, pll_bypass});
    apb(0, ADDR_DIV, 0);
    chk("div restored", SYS_SEL_RESET, rd & 32'h3f);
  endtask
  task automatic t_hiber;
    apb(1, ADDR_VREG, 32'h63);
    repeat (2) @(posedge clock);
    chk("target", BASE + 12'h096, regulator_target_mv);
    chk("reg ctl", 2'b11, {regulator_disable, regulator_bypass});
    for (int s = 0; s < 8; s++) begin
      apb(1, ADDR_DIV, 32'h2);
      apb(1, ADDR_VREG, 32'h73);
      wait_mode(M_HIBER, 0);
      repeat (2) @(posedge clock);
      chk("supply", 0, {internal_core_supply_en, regulator_target_mv});
      chk("hiz", 1, pins_hiz);
      if (s < 7) hib_wake <= 7'(1 << s);
      else ext_reset_n <= 1'b0;
      wait_mode(M_RESET, 0);
      repeat (2) @(posedge clock);
      chk("rst out", 1, sys_reset_out);
      hib_wake <= 7'h00;
      ext_reset_n <= 1'b1;
      wait_mode(M_FULL_ON, 0);
      apb(0, ADDR_VREG, 0);
      chk("vreg kept", 32'h63, rd & 32'h7f);
      apb(0, ADDR_DIV, 0);
      chk("div lost", SYS_SEL_RESET, rd & 32'h3f);
    end
  endtask
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, rtc_irq, paddr, pwdata, hib_wake, sleep_wake} = '0;
    ext_reset_n = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_div();
    t_mult();
    t_sleep();
    t_deep();
    t_hiber();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    test_done();
  end
endmodule
